/* File: hw/option_reset_watchdog_ctrl_map.vh */
// register map, option bit layout and timing counts of the option/reset/watchdog block
`ifndef OPTION_RESET_WATCHDOG_CTRL_MAP_VH
`define OPTION_RESET_WATCHDOG_CTRL_MAP_VH

// ==========================================================
// register indices (byte address is four times the index)
`define OPT_PRI_IDX   10'h012
`define OPT_SEC_IDX   10'h013
`define WDOG_SVC_IDX  10'h3f0
`define CTRL_IDX      10'h014
`define STAT_IDX      10'h015
`define MASK_IDX      10'h016

// ==========================================================
// primary option byte fields
`define OPT_SHORT_DLY 7
`define OPT_OSC3      6
`define OPT_OSCRC     5
`define OPT_HALT      4
`define OPT_PDINH     3
`define OPT_PAIRQ     2
`define OPT_EXTSENS   1
`define OPT_WDEN      0

// ==========================================================
// security byte fields, service and control fields
`define SEC_HI        1
`define SEC_LO        0
`define WDSVC_BIT     0
`define CTRL_RATE_HI  1
`define CTRL_RATE_LO  0

// ==========================================================
// status and mask bit positions
`define ST_SWI        0
`define ST_EXT        1
`define ST_PORT       2
`define ST_TOVF       3
`define ST_RTI        4
`define ST_WDOG       5
`define ST_ILLAD      6
`define ST_PIN        7

// ==========================================================
// reset values and timing counts (bus cycles)
`define CTRL_RST      2'h0
`define MASK_RST      8'h00
`define STAT_RST      8'h00
`define DLY_LONG      12'd4064
`define DLY_SHORT     12'd16

`endif

/* File: hw/option_reset_watchdog_ctrl.v */
// option bytes, reset sequencing, watchdog and interrupt detect
// Function
// - options come from two read-only byte registers at indices 12h and 13h.
// - bit 6 selects three-pin oscillator and bit 5 the RC oscillator.
// - reset comes from power-on, reset pin low, watchdog timeout, illegal address; no low-voltage reset.
// - interrupt sources are software, irq pin low, port A low nibble high, timer overflow and rti.
// - port A irq enable and external irq sensitivity come from the first option byte.
// - level mode takes falling edge and low level, else falling edge only; port enable gates port inputs.
// - the watchdog runs only when option bit 0 is one.
// - writing zero to bit 0 at index 3f0h restarts the watchdog count.
// - watchdog timeout is chosen by the two rate select bits.
// - after reset or stop exit wait 4064 cycles, or 16 when option bit 7 is set.
// - security is on unless both security bits are one.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "option_reset_watchdog_ctrl_map.vh"

module option_reset_watchdog_ctrl #(
  parameter [23:0] WDOG_BASE = 24'd131072
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire [11:0] adr_i,
  input  wire [31:0] dat_i,
  output wire [31:0] dat_o,
  input  wire        we_i,
  input  wire [3:0]  sel_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  output wire        ack_o,
  input  wire [7:0]  option_primary_i,
  input  wire [7:0]  option_security_i,
  input  wire        ext_reset_n_i,
  input  wire        illegal_addr_i,
  input  wire        stop_exit_i,
  input  wire        swi_i,
  input  wire        irq_pin_n_i,
  input  wire [3:0]  port_a_i,
  input  wire        timer_ovf_i,
  input  wire        rti_i,
  output wire        sys_reset_o,
  output wire        osc_stable_o,
  output wire        three_pin_osc_select_o,
  output wire        resistor_cap_osc_select_o,
  output wire        stop_to_halt_o,
  output wire        pulldown_inhibit_o,
  output wire        security_en_o,
  output wire        watchdog_active_o,
  output wire        irq_o
);

  localparam [1:0] ST_HOLD = 2'd0;
  localparam [1:0] ST_RUN  = 2'd1;
  localparam [1:0] ST_WAKE = 2'd2;

  // ==========================================================
  // helpers
  function hit;
    input [11:0] adr;
    input [9:0]  idx;
    begin
      hit = (adr[11:2] == idx);
    end
  endfunction

  function [23:0] wd_limit;
    input [1:0]  rate;
    input [23:0] base;
    begin
      wd_limit = base << rate;
    end
  endfunction

  // ==========================================================
  // state
  reg [7:0]  mask_option_config_r;
  reg [7:0]  sec_opt_r;
  reg [1:0]  rate_r;
  reg [7:0]  stat_r;
  reg [7:0]  stat_nxt;
  reg [7:0]  mask_r;
  reg        ack_r;
  reg [31:0] dat_r;
  reg [31:0] rd_nxt;
  reg [1:0]  st_r;
  reg [1:0]  st_nxt;
  reg [11:0] dly_r;
  reg [23:0] wd_cnt_r;
  reg        irq_r;
  reg        pin_s1_r;
  reg        pin_s2_r;
  reg        irqp_s1_r;
  reg        irqp_s2_r;
  reg        irqp_s3_r;
  reg [3:0]  pa_s1_r;
  reg [3:0]  pa_s2_r;

  wire [11:0] dly_lim;
  wire        dly_done;
  wire        wd_en;
  wire        wd_to;
  wire        wr_go;
  wire        svc_wr;
  wire        rst_req;
  wire        in_rst;
  wire        ext_evt;
  wire        port_evt;
  wire        port_irq_enable;
  wire        ext_irq_sensitivity;

  // ==========================================================
  // option decode
  assign dly_lim = mask_option_config_r[`OPT_SHORT_DLY] ?
                   `DLY_SHORT : `DLY_LONG;
  assign three_pin_osc_select_o    = mask_option_config_r[`OPT_OSC3];
  assign resistor_cap_osc_select_o = mask_option_config_r[`OPT_OSCRC];
  assign stop_to_halt_o     = mask_option_config_r[`OPT_HALT];
  assign pulldown_inhibit_o = mask_option_config_r[`OPT_PDINH];
  assign port_irq_enable     = mask_option_config_r[`OPT_PAIRQ];
  assign ext_irq_sensitivity = mask_option_config_r[`OPT_EXTSENS];
  assign security_en_o = ~(sec_opt_r[`SEC_HI] & sec_opt_r[`SEC_LO]);
  assign wd_en = mask_option_config_r[`OPT_WDEN];

  // ==========================================================
  // bus slave: ack one cycle after request, write on ack edge
  assign wr_go  = cyc_i & stb_i & we_i & ack_r;
  assign svc_wr = wr_go & sel_i[0] & hit(adr_i, `WDOG_SVC_IDX) &
                  ~dat_i[`WDSVC_BIT];
  assign ack_o  = ack_r;
  assign dat_o  = dat_r;

  always @* begin
    rd_nxt = 32'h0000_0000;
    if (hit(adr_i, `OPT_PRI_IDX))
      rd_nxt[7:0] = mask_option_config_r;
    else if (hit(adr_i, `OPT_SEC_IDX))
      rd_nxt[7:0] = sec_opt_r;
    else if (hit(adr_i, `CTRL_IDX))
      rd_nxt[1:0] = rate_r;
    else if (hit(adr_i, `STAT_IDX))
      rd_nxt[7:0] = stat_r;
    else if (hit(adr_i, `MASK_IDX))
      rd_nxt[7:0] = mask_r;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_r <= cyc_i & stb_i & ~ack_r;
      if (cyc_i & stb_i & ~ack_r & ~we_i)
        dat_r <= rd_nxt;
      else if (ack_r)
        dat_r <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // pin synchronisers
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r  <= 1'b1;
      pin_s2_r  <= 1'b1;
      irqp_s1_r <= 1'b1;
      irqp_s2_r <= 1'b1;
      irqp_s3_r <= 1'b1;
      pa_s1_r   <= 4'h0;
      pa_s2_r   <= 4'h0;
    end else if (ce_i) begin
      pin_s1_r  <= ext_reset_n_i;
      pin_s2_r  <= pin_s1_r;
      irqp_s1_r <= irq_pin_n_i;
      irqp_s2_r <= irqp_s1_r;
      irqp_s3_r <= irqp_s2_r;
      pa_s1_r   <= port_a_i;
      pa_s2_r   <= pa_s1_r;
    end
  end

  // ==========================================================
  // reset sequencer
  assign wd_to   = wd_en & (st_r != ST_HOLD) &
                   (wd_cnt_r >= wd_limit(rate_r, WDOG_BASE) - 24'd1);
  assign rst_req = ~pin_s2_r | wd_to | illegal_addr_i;
  assign in_rst  = (st_r == ST_HOLD);
  assign dly_done = (dly_r >= dly_lim - 12'd1);

  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_HOLD: begin
        if (dly_done)
          st_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (stop_exit_i)
          st_nxt = ST_WAKE;
      end
      ST_WAKE: begin
        if (dly_done)
          st_nxt = ST_RUN;
      end
      default: st_nxt = ST_HOLD;
    endcase
    if (rst_req)
      st_nxt = ST_HOLD;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_r  <= ST_HOLD;
      dly_r <= 12'd0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      if (st_nxt != st_r || rst_req)
        dly_r <= 12'd0;
      else if (st_r != ST_RUN)
        dly_r <= dly_r + 12'd1;
    end
  end

  assign sys_reset_o  = in_rst;
  assign osc_stable_o = (st_r == ST_RUN);

  // options are caught while the reset sequence holds
  always @(posedge clk_i) begin
    if (rst_i || (ce_i && in_rst)) begin
      mask_option_config_r <= option_primary_i;
      sec_opt_r            <= option_security_i;
    end
  end

  // ==========================================================
  // watchdog counter
  always @(posedge clk_i) begin
    if (rst_i) begin
      wd_cnt_r <= 24'd0;
    end else if (ce_i) begin
      if (in_rst || !wd_en || svc_wr || wd_to)
        wd_cnt_r <= 24'd0;
      else
        wd_cnt_r <= wd_cnt_r + 24'd1;
    end
  end

  assign watchdog_active_o = wd_en;

  // ==========================================================
  // control and mask registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      rate_r <= `CTRL_RST;
      mask_r <= `MASK_RST;
    end else if (ce_i) begin
      if (in_rst) begin
        rate_r <= `CTRL_RST;
        mask_r <= `MASK_RST;
      end else if (wr_go && sel_i[0]) begin
        if (hit(adr_i, `CTRL_IDX))
          rate_r <= dat_i[`CTRL_RATE_HI:`CTRL_RATE_LO];
        if (hit(adr_i, `MASK_IDX))
          mask_r <= dat_i[7:0];
      end
    end
  end

  // ==========================================================
  // interrupt detect and sticky status
  assign ext_evt = (irqp_s3_r & ~irqp_s2_r) |
                   (ext_irq_sensitivity & ~irqp_s2_r);
  assign port_evt = port_irq_enable & (|pa_s2_r);

  always @* begin
    stat_nxt = stat_r;
    if (wr_go && sel_i[0] && hit(adr_i, `STAT_IDX))
      stat_nxt = stat_r & ~dat_i[7:0];
    if (!in_rst) begin
      stat_nxt[`ST_SWI]  = stat_nxt[`ST_SWI]  | swi_i;
      stat_nxt[`ST_EXT]  = stat_nxt[`ST_EXT]  | ext_evt;
      stat_nxt[`ST_PORT] = stat_nxt[`ST_PORT] | port_evt;
      stat_nxt[`ST_TOVF] = stat_nxt[`ST_TOVF] | timer_ovf_i;
      stat_nxt[`ST_RTI]  = stat_nxt[`ST_RTI]  | rti_i;
    end
    stat_nxt[`ST_WDOG]  = stat_nxt[`ST_WDOG]  | wd_to;
    stat_nxt[`ST_ILLAD] = stat_nxt[`ST_ILLAD] | illegal_addr_i;
    stat_nxt[`ST_PIN]   = stat_nxt[`ST_PIN]   | ~pin_s2_r;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= `STAT_RST;
      irq_r  <= 1'b0;
    end else if (ce_i) begin
      stat_r <= stat_nxt;
      irq_r  <= |(stat_nxt & mask_r);
    end
  end

  assign irq_o = irq_r;

endmodule // option_reset_watchdog_ctrl

/* File: test/orw_checker.sv */
// assertion checker of the option/reset/watchdog block
`timescale 1ns/1ps
module orw_checker #(parameter [23:0] WDOG_BASE = 24'd32) (
  input wire        clk_i,
  input wire        rst_i,
  input wire        ce_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        ack_o,
  input wire [31:0] dat_o,
  input wire [7:0]  option_primary_i,
  input wire [7:0]  option_security_i,
  input wire        ext_reset_n_i,
  input wire        illegal_addr_i,
  input wire        stop_exit_i,
  input wire        sys_reset_o,
  input wire        osc_stable_o,
  input wire        security_en_o
);
  // ==========
  // hold length
  logic [12:0] hold_r;
  wire  [12:0] len = option_primary_i[7] ? 13'h10 : 13'hfe0;
  always @(posedge clk_i)
    if (rst_i || !sys_reset_o || !ext_reset_n_i || illegal_addr_i) hold_r <= 13'h0;
    else if (ce_i) hold_r <= hold_r + 13'h1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE: assert property (ack_o |=> !ack_o) else $error("ack too long");
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o) else $error("no ack");
  AST_DAT_ZERO: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
  AST_ILL_RST: assert property (illegal_addr_i && ce_i |-> ##[1:3] sys_reset_o) else $error("no reset");
  AST_PIN_RST: assert property ((!ext_reset_n_i && ce_i) [*4] |=> sys_reset_o) else $error("no pin reset");
  AST_HOLD_LEN: assert property ($fell(sys_reset_o) |-> hold_r + 13'h1 >= len && hold_r <= len + 13'h3)
    else $error("bad hold length");
  AST_STOP: assert property (stop_exit_i && osc_stable_o |=> (!osc_stable_o && !sys_reset_o) [*8])
    else $error("bad stop restart");
  AST_SEC: assert property (osc_stable_o && $stable(option_security_i) |->
    security_en_o == !(&option_security_i[1:0])) else $error("bad security");
endmodule // orw_checker

bind option_reset_watchdog_ctrl orw_checker #(.WDOG_BASE(WDOG_BASE)) i_orw_checker (.*);

/* File: test/tb_option_reset_watchdog_ctrl.sv */
// self-checking bench of the option/reset/watchdog block
`timescale 1ns/1ps
`include "option_reset_watchdog_ctrl_map.vh"
module tb_option_reset_watchdog_ctrl;
  localparam int WB = 32;
  logic        clk_i, rst_i, ce_i, we_i, cyc_i, stb_i, illegal_addr_i, stop_exit_i, swi_i;
  logic        irq_pin_n_i, timer_ovf_i, rti_i, ext_reset_n_i;
  logic [11:0] adr_i;
  logic [31:0] dat_i, q;
  logic [3:0]  sel_i, port_a_i;
  logic [7:0]  option_primary_i, option_security_i, st, mk, p;
  wire  [31:0] dat_o;
  wire         ack_o, sys_reset_o, osc_stable_o, three_pin_osc_select_o, resistor_cap_osc_select_o, irq_o;
  wire         stop_to_halt_o, pulldown_inhibit_o, security_en_o, watchdog_active_o;
  integer      n_mismatch = 0, check_count = 0, n, i;
  option_reset_watchdog_ctrl #(.WDOG_BASE(WB)) i_option_reset_watchdog_ctrl (.*);
  initial begin
    clk_i = 0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    #160000;
    n_mismatch++;
    finish_test;
  end
  // ==========
  // tasks
  task finish_test;
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wb(input logic w, input logic [9:0] x, input logic [7:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, x, 26'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  task rd(input string nm, input logic [9:0] x, input logic [31:0] e);
    wb(0, x, 8'h0);
    chk(nm, e, q);
  endtask
  task run(input integer lo, input integer hi);
    n = 0;
    while (osc_stable_o !== 1'b1 && n < 9000) begin
      @(posedge clk_i);
      n++;
    end
    chk("delay", 1, n >= lo && n <= hi);
  endtask
  task rs(input logic [7:0] pr, input logic [7:0] se, input integer lo);
    @(posedge clk_i);
    {option_primary_i, option_security_i, rst_i} <= {pr, se, 1'b1};
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    run(lo, lo + 3);
    wb(1, `STAT_IDX, 8'hff);
    {st, mk} = 16'h0;
  endtask
  task ev(input integer k);
    @(posedge clk_i);
    case (k)
      0: swi_i <= 1;
      1: irq_pin_n_i <= 0;
      2: port_a_i <= 4'h1 << ($urandom % 4);
      3: timer_ovf_i <= 1;
      4: rti_i <= 1;
      6: illegal_addr_i <= 1;
      default: ext_reset_n_i <= k != 7;
    endcase
    @(posedge clk_i);
    {swi_i, timer_ovf_i, rti_i, illegal_addr_i, irq_pin_n_i} <= 5'h1;
    repeat (5) @(posedge clk_i);
    {ext_reset_n_i, port_a_i} <= 5'h10;
    repeat (3) @(posedge clk_i);
  endtask
  // ==========
  // scenarios
  initial begin
    {rst_i, ce_i, irq_pin_n_i, ext_reset_n_i, sel_i} = 8'hff;
    {we_i, cyc_i, stb_i, illegal_addr_i, stop_exit_i, swi_i, timer_ovf_i, rti_i, adr_i, dat_i, port_a_i} = 0;
    void'($urandom(56367));
    p = $urandom;
    {option_primary_i, option_security_i, st, mk} = {1'b1, p[6:3], 3'b100, 24'h0};
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    run(16, 19);
    rd("pri", `OPT_PRI_IDX, option_primary_i);
    rd("sec", `OPT_SEC_IDX, option_security_i);
    wb(1, `CTRL_IDX, 8'hff);
    rd("ctrl", `CTRL_IDX, 3);
    wb(1, 10'h1, 8'hff);
    rd("hole", 10'h1, 0);
    rd("svc", `WDOG_SVC_IDX, 0);
    wb(1, `MASK_IDX, 8'hff);
    mk = 8'hff;
    for (i = 0; i < 8; i++) begin
      ev(i);
      if (i != 5) st[i] = 1;
      if (i > 5) begin
        run(1, 40);
        mk = 0;
      end
      rd("stat", `STAT_IDX, st);
      chk("irq", |(st & mk), irq_o);
    end
    wb(1, `STAT_IDX, 8'hff);
    wb(1, `MASK_IDX, 8'h01);
    ev(4);
    chk("masked", 0, irq_o);
    ev(0);
    chk("unmasked", 1, irq_o);
    wb(1, `STAT_IDX, 8'h01);
    repeat (3) @(posedge clk_i);
    rd("w1c", `STAT_IDX, 8'h10);
    chk("cleared", 0, irq_o);
    for (i = 0; i < 4; i++) begin
      p = $urandom;
      rs({1'b1, p[6:3], 3'b000}, {p[7:2], i[1:0]}, 16);
      chk("opt", {p[6:3], i[1:0] != 2'b11, 1'b0}, {three_pin_osc_select_o, resistor_cap_osc_select_o,
        stop_to_halt_o, pulldown_inhibit_o, security_en_o, watchdog_active_o});
    end
    rs(8'h82, 0, 16);
    ev(2);
    irq_pin_n_i <= 0;
    repeat (200) @(posedge clk_i);
    wb(1, `STAT_IDX, 8'hff);
    repeat (3) @(posedge clk_i);
    rd("level", `STAT_IDX, 2);
    irq_pin_n_i <= 1;
    for (i = 0; i < 4; i++) begin
      rs(8'h81, 0, 16);
      wb(1, `CTRL_IDX, i[7:0]);
      wb(1, `WDOG_SVC_IDX, 8'hfe);
      @(posedge clk_i);
      ce_i <= 0;
      repeat (300) @(posedge clk_i);
      ce_i <= 1;
      n = 0;
      while (sys_reset_o !== 1'b1 && n < 600) begin
        @(posedge clk_i);
        n++;
      end
      chk("wdog", 1, n >= (WB << i) && n <= (WB << i) + 2);
      run(14, 18);
      rd("wstat", `STAT_IDX, 8'h20);
    end
    rs(8'h80, 0, 16);
    stop_exit_i <= 1;
    @(posedge clk_i);
    stop_exit_i <= 0;
    @(posedge clk_i);
    run(13, 17);
    chk("stop", 0, sys_reset_o);
    rs(8'h00, 0, 4064);
    finish_test;
  end
endmodule // tb_option_reset_watchdog_ctrl
